//--- inc/irq_vector_pkg.sv
// Summary of operation
// - Vectors occupy words 0FFE0h to 0FFFFh; priority rises with address, 0 to 15.
// - Each vector word holds the 16-bit handler start address loaded on acceptance.
// - Power-up, external reset and watchdog reset use 0FFFEh at priority 15.
// - Pin non-maskable and oscillator fault share 0FFFCh at priority 14.
// - Timer compare channel 0 has its own maskable vector 0FFF2h, priority 9.
// - Channels 1, 2 and overflow share maskable 0FFF0h, priority 8; flags in timer.
// - All eight port-two flags feed maskable 0FFE6h at priority 3.
// - The eight port-one flags share maskable 0FFE4h at priority 2.
// - Watchdog enable gates the interval request at 0FFF4h only in interval mode.
// - Unassigned flag and enable bits have no storage and read as zero.
// - Watchdog flag bit 0 sets on overflow in either mode or on a wrong key write.
// - Watchdog flag clears on power-up, pin reset or a register write; power-up clear keeps it.
// - Oscillator fault flag bit 1 sets on fault; power-up clear sets it; read/write.
// - Pin flag bit 4 sets on pin event; power-up clear clears it; read/write.
// - Oscillator fault enable gates the fault flag onto the shared vector.
// - Pin enable gates the pin flag onto the shared vector.
// - Watchdog-mode expiry generates a system reset taken through the top vector.
// - Any enabled request wakes from low power; the mode resumes after return.
package irq_vector_pkg;
	// Register byte addresses; the flag register sits at index 2.
	localparam logic [7:0] REG_IDX_ENABLES = 8'h00;
	localparam logic [7:0] REG_IDX_FLAGS   = 8'h02;
	localparam logic [7:0] ADR_ENABLES     = 8'(REG_IDX_ENABLES * 4);
	localparam logic [7:0] ADR_FLAGS       = 8'(REG_IDX_FLAGS * 4);
	localparam logic [7:0] ADR_CONTROL     = 8'h10;
	localparam logic [7:0] ADR_STATUS      = 8'h14;
	localparam logic [7:0] ADR_VECT_BASE   = 8'h40;
	localparam logic [7:0] ADR_VECT_LAST   = 8'h7C;
	// Bit positions shared by the flag and enable registers, and the control mode bit.
	localparam int BIT_WATCHDOG = 0;
	localparam int BIT_OSC      = 1;
	localparam int BIT_PIN_NM   = 4;
	localparam int BIT_WD_MODE  = 0;
	// Reset values.
	localparam logic       RST_OSC_FLAG   = 1'b1;
	localparam logic       RST_WD_MODE    = 1'b1;
	localparam logic [15:0] RST_VECTOR    = 16'h0000;
	// Vector table geometry and slot priorities.
	localparam logic [15:0] VECT_BASE_ADR = 16'hFFE0;
	localparam int          NUM_SLOTS     = 16;
	localparam logic [3:0] PRI_RESET      = 4'hF;
	localparam logic [3:0] PRI_NMI        = 4'hE;
	localparam logic [3:0] PRI_WD_INTVL   = 4'hA;
	localparam logic [3:0] PRI_CC0        = 4'h9;
	localparam logic [3:0] PRI_TIMER_SHR  = 4'h8;
	localparam logic [3:0] PRI_PORT_TWO   = 4'h3;
	localparam logic [3:0] PRI_PORT_ONE   = 4'h2;
endpackage : irq_vector_pkg

//--- design/irq_priority_pick.sv
`timescale 1ns/1ns
// Picks the highest set bit of the pending vector.
module irq_priority_pick (
	input  wire logic [15:0] i_pending,
	output logic             o_valid,
	output logic [3:0]       o_index
);
	import irq_vector_pkg::*;

	// Scan upward so the highest set slot wins.
	always_comb begin
		o_valid = 1'b0;
		o_index = 4'h0;
		for (int i = 0; i < NUM_SLOTS; i++) begin
			if (i_pending[i]) begin
				o_valid = 1'b1;
				o_index = 4'(i);
			end
		end
	end
endmodule : irq_priority_pick

//--- design/interrupt_vector_sfr.sv
// Local design decision: register access over Wishbone.
`timescale 1ns/1ns
// Interrupt vectoring, priority and special-function flag/enable bits.
module interrupt_vector_sfr (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	// Classic Wishbone slave.
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic             o_wb_ack,
	output logic [31:0]      o_wb_dat,
	// Reset and event sources.
	input  wire logic        i_power_up_clear,
	input  wire logic        i_pin_reset,
	input  wire logic        i_pin_nm_event,
	input  wire logic        i_osc_fault,
	input  wire logic        i_wdt_expire,
	input  wire logic        i_wdt_key_violation,
	input  wire logic        i_capture_compare_flag,
	input  wire logic [2:0]  i_timer_shared_flags,
	input  wire logic [7:0]  i_port_one_flags,
	input  wire logic [7:0]  i_port_two_flags,
	// Processor core side.
	input  wire logic        i_gie,
	input  wire logic        i_irq_ack,
	input  wire logic        i_reti,
	input  wire logic [2:0]  i_lpm_mode,
	output logic             o_irq_req,
	output logic [15:0]      o_irq_vector_adr,
	output logic [15:0]      o_irq_handler,
	output logic [3:0]       o_irq_priority,
	output logic             o_system_reset,
	output logic             o_wake,
	output logic             o_lpm_resume,
	output logic [2:0]       o_lpm_resume_mode
);
	import irq_vector_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic              wb_ack;
		logic [31:0]       wb_dat;
		logic              watchdog_flag;
		logic              osc_fault_flag;
		logic              pin_nm_flag;
		logic              watchdog_irq_enable;
		logic              osc_fault_irq_enable;
		logic              pin_nm_irq_enable;
		logic              wd_mode;
		logic              reset_req;
		logic [15:0][15:0] vect;
		logic              irq_req;
		logic [15:0]       irq_vector_adr;
		logic [15:0]       irq_handler;
		logic [3:0]        irq_priority;
		logic              system_reset;
		logic              wake;
		logic [2:0]        lpm_saved;
		logic              lpm_resume;
		logic [2:0]        lpm_resume_mode;
	} state_t;

	state_t state_ff;
	state_t nxt_state;

	logic [15:0] pending;
	logic        pick_valid;
	logic [3:0]  pick_index;
	logic        wb_req;
	logic        wb_commit;
	logic [3:0]  vect_slot;
	logic        vect_hit;

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Word address of a vector slot.
	function automatic logic [15:0] slot_adr(input logic [3:0] idx);
		slot_adr = VECT_BASE_ADR + {11'h000, idx, 1'b0};
	endfunction : slot_adr

	// Merge a 16-bit word under the two low byte enables.
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] wr, input logic [1:0] sel);
		merge16 = old;
		if (sel[0]) begin
			merge16[7:0] = wr[7:0];
		end
		if (sel[1]) begin
			merge16[15:8] = wr[15:8];
		end
	endfunction : merge16

	////////////////////////////////////////////////////////////////////////
	// Request gathering and priority selection.

	// Each source lands in its priority slot (pin and oscillator share slot 14); unassigned slots stay zero.
	always_comb begin
		pending = 16'h0000;
		pending[PRI_RESET] = state_ff.reset_req;
		pending[PRI_NMI] =
			(state_ff.pin_nm_flag & state_ff.pin_nm_irq_enable) |
			(state_ff.osc_fault_flag & state_ff.osc_fault_irq_enable);
		pending[PRI_WD_INTVL] = state_ff.watchdog_flag &
			state_ff.watchdog_irq_enable & ~state_ff.wd_mode & i_gie;
		pending[PRI_CC0] = i_capture_compare_flag & i_gie;
		pending[PRI_TIMER_SHR] = (|i_timer_shared_flags) & i_gie;
		pending[PRI_PORT_TWO] = (|i_port_two_flags) & i_gie;
		pending[PRI_PORT_ONE] = (|i_port_one_flags) & i_gie;
	end

	irq_priority_pick u_pick (
		.i_pending (pending),
		.o_valid   (pick_valid),
		.o_index   (pick_index)
	);

	// Bus decode; a write lands at the edge where the master sees ack.
	assign wb_req    = i_wb_cyc & i_wb_stb;
	assign wb_commit = wb_req & i_wb_we & state_ff.wb_ack;
	assign vect_hit  = (i_wb_adr >= ADR_VECT_BASE) &&
		(i_wb_adr <= ADR_VECT_LAST) && (i_wb_adr[1:0] == 2'b00);
	assign vect_slot = 4'((i_wb_adr - ADR_VECT_BASE) >> 2);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb begin
		nxt_state = state_ff;
		nxt_state.system_reset = 1'b0;
		nxt_state.lpm_resume   = 1'b0;

		// Bus answer one cycle after the request, dropped a cycle later.
		nxt_state.wb_ack = wb_req & ~state_ff.wb_ack;
		if (wb_req & ~state_ff.wb_ack) begin
			nxt_state.wb_dat = 32'h0000_0000;
			case (i_wb_adr)
				ADR_ENABLES: begin
					nxt_state.wb_dat[BIT_WATCHDOG] = state_ff.watchdog_irq_enable;
					nxt_state.wb_dat[BIT_OSC] = state_ff.osc_fault_irq_enable;
					nxt_state.wb_dat[BIT_PIN_NM] = state_ff.pin_nm_irq_enable;
				end
				ADR_FLAGS: begin
					nxt_state.wb_dat[BIT_WATCHDOG] = state_ff.watchdog_flag;
					nxt_state.wb_dat[BIT_OSC] = state_ff.osc_fault_flag;
					nxt_state.wb_dat[BIT_PIN_NM] = state_ff.pin_nm_flag;
				end
				ADR_CONTROL: begin
					nxt_state.wb_dat[BIT_WD_MODE] = state_ff.wd_mode;
				end
				ADR_STATUS: begin
					nxt_state.wb_dat[15:0] = pending;
					nxt_state.wb_dat[19:16] = pick_index;
					nxt_state.wb_dat[20] = pick_valid;
				end
				default: begin
					if (vect_hit) begin
						nxt_state.wb_dat[15:0] = state_ff.vect[vect_slot];
					end
				end
			endcase
		end

		// Software writes come first so hardware sets below win.
		if (wb_commit) begin
			case (i_wb_adr)
				ADR_ENABLES: begin
					if (i_wb_sel[0]) begin
						nxt_state.watchdog_irq_enable = i_wb_dat[BIT_WATCHDOG];
						nxt_state.osc_fault_irq_enable = i_wb_dat[BIT_OSC];
						nxt_state.pin_nm_irq_enable = i_wb_dat[BIT_PIN_NM];
					end
				end
				ADR_FLAGS: begin
					if (i_wb_sel[0]) begin
						nxt_state.watchdog_flag = i_wb_dat[BIT_WATCHDOG];
						nxt_state.osc_fault_flag = i_wb_dat[BIT_OSC];
						nxt_state.pin_nm_flag = i_wb_dat[BIT_PIN_NM];
					end
				end
				ADR_CONTROL: begin
					if (i_wb_sel[0]) begin
						nxt_state.wd_mode = i_wb_dat[BIT_WD_MODE];
					end
				end
				default: begin
					if (vect_hit) begin
						nxt_state.vect[vect_slot] = merge16(
							state_ff.vect[vect_slot], i_wb_dat[15:0],
							i_wb_sel[1:0]);
					end
				end
			endcase
		end

		// Core acceptance: reset request is consumed, non-maskable
		// enables drop so the handler is not re-entered, mode is kept.
		if (i_irq_ack & state_ff.irq_req) begin
			if (state_ff.irq_priority == PRI_RESET) begin
				nxt_state.reset_req = 1'b0;
			end
			if (state_ff.irq_priority == PRI_NMI) begin
				nxt_state.osc_fault_irq_enable = 1'b0;
				nxt_state.pin_nm_irq_enable = 1'b0;
			end
			nxt_state.lpm_saved = i_lpm_mode;
		end

		// On return the previous low-power mode is handed back.
		if (i_reti) begin
			nxt_state.lpm_resume = 1'b1;
			nxt_state.lpm_resume_mode = state_ff.lpm_saved;
		end

		// A power-up clear restores its bits but leaves the watchdog flag.
		if (i_power_up_clear) begin
			nxt_state.osc_fault_flag = RST_OSC_FLAG;
			nxt_state.pin_nm_flag = 1'b0;
			nxt_state.watchdog_irq_enable = 1'b0;
			nxt_state.osc_fault_irq_enable = 1'b0;
			nxt_state.pin_nm_irq_enable = 1'b0;
			nxt_state.wd_mode = RST_WD_MODE;
		end

		// Pin reset in either watchdog mode clears the watchdog flag and restarts.
		if (i_pin_reset) begin
			nxt_state.watchdog_flag = 1'b0;
			nxt_state.reset_req = 1'b1;
		end

		// Hardware events set their flags; a set beats any clear.
		if (i_osc_fault) begin
			nxt_state.osc_fault_flag = 1'b1;
		end
		if (i_pin_nm_event) begin
			nxt_state.pin_nm_flag = 1'b1;
		end
		if (i_wdt_key_violation) begin
			nxt_state.watchdog_flag = 1'b1;
			nxt_state.reset_req = 1'b1;
			nxt_state.system_reset = 1'b1;
		end
		if (i_wdt_expire) begin
			nxt_state.watchdog_flag = 1'b1;
			if (state_ff.wd_mode) begin
				nxt_state.reset_req = 1'b1;
				nxt_state.system_reset = 1'b1;
			end
		end

		// Present the winner; hold off one cycle after an acceptance.
		nxt_state.irq_req = pick_valid & ~(i_irq_ack & state_ff.irq_req);
		nxt_state.irq_priority = pick_index;
		nxt_state.irq_vector_adr = slot_adr(pick_index);
		nxt_state.irq_handler = state_ff.vect[pick_index];
		nxt_state.wake = pick_valid;
	end

	////////////////////////////////////////////////////////////////////////
	// State register.

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff <= '0;
			state_ff.osc_fault_flag <= RST_OSC_FLAG;
			state_ff.wd_mode <= RST_WD_MODE;
			state_ff.reset_req <= 1'b1;
			state_ff.irq_vector_adr <= VECT_BASE_ADR;
		end else if (i_ce) begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register.

	assign o_wb_ack          = state_ff.wb_ack;
	assign o_wb_dat          = state_ff.wb_dat;
	assign o_irq_req         = state_ff.irq_req;
	assign o_irq_vector_adr  = state_ff.irq_vector_adr;
	assign o_irq_handler     = state_ff.irq_handler;
	assign o_irq_priority    = state_ff.irq_priority;
	assign o_system_reset    = state_ff.system_reset;
	assign o_wake            = state_ff.wake;
	assign o_lpm_resume      = state_ff.lpm_resume;
	assign o_lpm_resume_mode = state_ff.lpm_resume_mode;
endmodule : interrupt_vector_sfr

//--- tb/interrupt_vector_sfr_properties.sv
`timescale 1ns/1ns
// Watches the bus and core-side ports of the interrupt block.
module interrupt_vector_sfr_properties (
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	input wire logic        i_ce,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        o_wb_ack,
	input wire logic        i_gie,
	input wire logic        i_irq_ack,
	input wire logic        i_reti,
	input wire logic        i_wdt_key_violation,
	input wire logic        o_irq_req,
	input wire logic        o_wake,
	input wire logic [15:0] o_irq_vector_adr,
	input wire logic [3:0]  o_irq_priority,
	input wire logic        o_system_reset,
	input wire logic        o_lpm_resume
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////////////////
	// A bus request is taken once and answered by a single ack.
	sequence s_wb_taken;
		i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	sequence s_wb_answer;
		o_wb_ack ##1 !o_wb_ack;
	endsequence
	a_wb_single_ack: assert property (s_wb_taken |=> s_wb_answer)
		else $error("bus ack missing or too long");
	a_vector_word: assert property (o_irq_req |->
		o_irq_vector_adr == 16'hFFE0 + {o_irq_priority, 1'h0})
		else $error("vector address does not match priority");
	a_empty_slot: assert property (o_irq_req |->
		!(o_irq_priority inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7,
		4'hB, 4'hC, 4'hD}))
		else $error("unassigned slot selected");
	a_ack_drops_req: assert property (i_ce && i_irq_ack && o_irq_req
		|=> !o_irq_req)
		else $error("request stands after acceptance");
	a_key_reset: assert property (i_ce && i_wdt_key_violation
		|=> o_system_reset)
		else $error("no system reset after key violation");
	a_wake_req: assert property (o_irq_req |-> o_wake)
		else $error("request without wake");
	a_resume_return: assert property (i_ce && i_reti |=> o_lpm_resume)
		else $error("no resume after return");
	a_mask_gie: assert property (o_irq_req && o_irq_priority < 4'hE
		|-> $past(i_gie))
		else $error("maskable request without global enable");
endmodule : interrupt_vector_sfr_properties

bind interrupt_vector_sfr interrupt_vector_sfr_properties checker_inst (
	.i_clk, .i_rst_n, .i_ce, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .i_gie,
	.i_irq_ack, .i_reti, .i_wdt_key_violation, .o_irq_req, .o_wake,
	.o_irq_vector_adr, .o_irq_priority, .o_system_reset, .o_lpm_resume
);

//--- tb/core_model.sv
`timescale 1ns/1ns
// Stand-in processor core: accepts a request, later returns from it.
module core_model (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_enable,
	input  wire logic i_slow,
	input  wire logic i_req,
	output logic      o_ack,
	output logic      o_reti
);
	logic [3:0] wait_ff;
	logic [3:0] ret_ff;
	// Acks at most every fifth cycle; a slow core thinks a while first.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wait_ff <= '0;
			ret_ff  <= '0;
			o_ack   <= '0;
			o_reti  <= '0;
		end else begin
			o_ack  <= '0;
			o_reti <= (ret_ff == 4'h1);
			if (ret_ff != '0)
				ret_ff <= ret_ff - 4'h1;
			if (i_enable && i_req && !o_ack && ret_ff == '0) begin
				wait_ff <= wait_ff + 4'h1;
				if (wait_ff >= (i_slow ? 4'h6 : 4'h0)) begin
					o_ack   <= 1'h1;
					wait_ff <= '0;
					ret_ff  <= 4'h4;
				end
			end
		end
	end
endmodule : core_model

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
	import irq_vector_pkg::*;
	logic i_clk = '0, i_rst_n = '0, i_ce = 1'h1, i_wb_cyc = '0;
	logic i_wb_stb = '0, i_wb_we = '0, i_power_up_clear = '0;
	logic i_pin_reset = '0, i_pin_nm_event = '0, i_osc_fault = '0;
	logic i_wdt_expire = '0, i_wdt_key_violation = '0, i_gie = '0;
	logic i_capture_compare_flag = '0, core_on = '0, core_slow = '0;
	logic i_irq_ack, i_reti, o_wb_ack, o_irq_req, o_system_reset, o_wake;
	logic o_lpm_resume;
	logic [7:0] i_wb_adr = '0, i_port_one_flags = '0, i_port_two_flags = '0;
	logic [3:0] i_wb_sel = '0, o_irq_priority;
	logic [31:0] i_wb_dat = '0, o_wb_dat, rd;
	logic [2:0] i_timer_shared_flags = '0, i_lpm_mode = '0, o_lpm_resume_mode;
	logic [15:0] o_irq_vector_adr, o_irq_handler;
	logic [3:0] pri_tab [6] = '{4'h9, 4'h8, 4'h8, 4'h8, 4'h3, 4'h2};
	int num_errors = 0, checked = 0, cycles = 0;
	interrupt_vector_sfr interrupt_vector_sfr_inst (.i_clk, .i_rst_n, .i_ce,
		.i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
		.o_wb_ack, .o_wb_dat, .i_power_up_clear, .i_pin_reset, .i_pin_nm_event,
		.i_osc_fault, .i_wdt_expire, .i_wdt_key_violation,
		.i_capture_compare_flag, .i_timer_shared_flags, .i_port_one_flags,
		.i_port_two_flags, .i_gie, .i_irq_ack, .i_reti, .i_lpm_mode,
		.o_irq_req, .o_irq_vector_adr, .o_irq_handler, .o_irq_priority,
		.o_system_reset, .o_wake, .o_lpm_resume, .o_lpm_resume_mode);
	core_model core_model_inst (.i_clk, .i_rst_n, .i_enable(core_on),
		.i_slow(core_slow), .i_req(o_irq_req), .o_ack(i_irq_ack),
		.o_reti(i_reti));
	////////////////////////////////////////////////////////////////////////
	// Clock and a ceiling on the run length.
	always #20 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic tick(int n);
		repeat (n) @(posedge i_clk);
	endtask : tick
	// Classic single bus cycle; read data lands in rd.
	task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat);
		@(posedge i_clk);
		{i_wb_cyc, i_wb_stb, i_wb_we, i_wb_sel} <= {2'h3, we, 4'hF};
		i_wb_adr <= adr;
		i_wb_dat <= dat;
		do @(posedge i_clk); while (o_wb_ack !== 1'h1);
		rd = o_wb_dat;
		{i_wb_cyc, i_wb_stb, i_wb_we} <= '0;
	endtask : wb
	// Drives one source or event input by number.
	task automatic drive(int k, logic v);
		case (k)
			0: i_capture_compare_flag <= v;
			1, 2, 3: i_timer_shared_flags[k-1] <= v;
			4: i_port_two_flags[7] <= v;
			5: i_port_one_flags[0] <= v;
			6: i_osc_fault <= v;
			7: i_pin_nm_event <= v;
			8: i_wdt_key_violation <= v;
			9: i_power_up_clear <= v;
			10: i_pin_reset <= v;
			default: i_wdt_expire <= v;
		endcase
	endtask : drive
	task automatic pulse(int k);
		drive(k, 1'h1);
		@(posedge i_clk);
		drive(k, '0);
	endtask : pulse
	task automatic expect_irq(logic req, logic [3:0] pri);
		tick(3);
		check("request", o_irq_req, req);
		check("wake", o_wake, req);
		if (req) begin
			check("priority", o_irq_priority, pri);
			check("vector", o_irq_vector_adr, 16'hFFE0 + {pri, 1'h0});
			check("handler", o_irq_handler, 16'hC000 + pri);
		end
	endtask : expect_irq
	task automatic accept_all;
		core_on <= 1'h1;
		tick(12);
		core_on <= '0;
		expect_irq('0, '0);
	endtask : accept_all
	task automatic conclude;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////////////////
	// Main sequence of register, vector and event scenarios.
	initial begin
		tick(10);
		i_rst_n <= 1'h1;
		for (int n = 0; n < 16; n++)
			wb(1'h1, ADR_VECT_BASE + 8'(4 * n), 32'hC000 + n);
		wb('0, ADR_VECT_BASE + 8'h3C, '0);
		check("vector word", rd, 32'h0000_C00F);
		expect_irq(1'h1, 4'hF);
		accept_all();
		wb('0, ADR_FLAGS, '0);
		check("flags", rd, 32'h02);
		wb('0, ADR_ENABLES, '0);
		check("enables", rd, '0);
		wb(1'h1, ADR_FLAGS, 32'hFF);
		wb('0, ADR_FLAGS, '0);
		check("flags", rd, 32'h13);
		wb(1'h1, ADR_FLAGS, '0);
		wb('0, 8'h30, '0);
		check("unmapped", rd, '0);
		i_gie <= 1'h1;
		for (int k = 0; k < 6; k++) begin
			drive(k, 1'h1);
			expect_irq(1'h1, pri_tab[k]);
			drive(k, '0);
			expect_irq('0, '0);
		end
		drive(0, 1'h1);
		drive(5, 1'h1);
		expect_irq(1'h1, 4'h9);
		wb('0, ADR_STATUS, '0);
		check("status", rd, 32'h0019_0204);
		i_gie <= '0;
		expect_irq('0, '0);
		drive(0, '0);
		drive(5, '0);
		pulse(6);
		wb(1'h1, ADR_ENABLES, 32'h02);
		expect_irq(1'h1, 4'hE);
		wb(1'h1, ADR_ENABLES, '0);
		expect_irq('0, '0);
		wb(1'h1, ADR_FLAGS, '0);
		pulse(7);
		wb('0, ADR_FLAGS, '0);
		check("flags", rd, 32'h10);
		wb(1'h1, ADR_ENABLES, 32'h10);
		expect_irq(1'h1, 4'hE);
		wb(1'h1, ADR_ENABLES, '0);
		wb(1'h1, ADR_FLAGS, '0);
		pulse(8);
		tick(1);
		check("system reset", o_system_reset, 1'h1);
		expect_irq(1'h1, 4'hF);
		pulse(9);
		wb('0, ADR_FLAGS, '0);
		check("flags", rd, 32'h03);
		pulse(10);
		wb('0, ADR_FLAGS, '0);
		check("flags", rd, 32'h02);
		accept_all();
		pulse(11);
		tick(1);
		check("system reset", o_system_reset, 1'h1);
		accept_all();
		wb(1'h1, ADR_CONTROL, '0);
		wb(1'h1, ADR_ENABLES, 32'h01);
		wb(1'h1, ADR_FLAGS, '0);
		i_gie <= 1'h1;
		pulse(11);
		expect_irq(1'h1, 4'hA);
		wb(1'h1, ADR_CONTROL, 32'h01);
		expect_irq('0, '0);
		i_lpm_mode <= 3'h3;
		core_slow <= 1'h1;
		core_on <= 1'h1;
		drive(5, 1'h1);
		for (int i = 0; i < 60 && o_lpm_resume !== 1'h1; i++)
			@(posedge i_clk);
		check("resume", o_lpm_resume, 1'h1);
		check("resume mode", o_lpm_resume_mode, 3'h3);
		core_on <= '0;
		drive(5, '0);
		tick(4);
		// A fault while the clock enable is low must leave the flags frozen.
		i_ce <= '0;
		pulse(6);
		i_ce <= 1'h1;
		wb('0, ADR_FLAGS, '0);
		check("frozen flags", rd, 32'h01);
		conclude();
	end
endmodule : tb
